// >>> core/ptc_pkg.sv
// Purpose: shared constants, types and helpers of the paired timer unit
// Assumes: 32-bit AHB-Lite word registers, one clock hclk
// Notes:   prescaler taps and register decode live here for both files
`default_nettype none

package ptc_pkg;

    // geometry
    localparam int PAIRS = 2;
    localparam int TIMER_W = 8;
    localparam int PRE_W = 11;
    localparam int SHIFT_W = 4;
    localparam int PAIR_SEL_BIT = 5;
    localparam int MAP_TOP_BIT = 6;

    // register offsets inside one pair block
    localparam logic [4:0] OFS_MODE_A = 5'h00;
    localparam logic [4:0] OFS_MODE_B = 5'h04;
    localparam logic [4:0] OFS_COUNT_LO = 5'h08;
    localparam logic [4:0] OFS_COUNT_HI = 5'h0C;
    localparam logic [4:0] OFS_FLAG = 5'h10;

    // first_mode_register fields
    localparam int FA_CLK_LSB = 0;
    localparam int FA_CAP_BIT = 3;
    localparam int FA_EDGE_LSB = 4;
    // second_mode_register fields
    localparam int FB_CLK_LSB = 0;
    localparam int FB_CAP_BIT = 2;
    localparam int FB_PWE_BIT = 3;
    localparam int FB_CASC_BIT = 4;
    localparam int FB_CMP_BIT = 5;
    // flag register fields
    localparam int FL_LO_BIT = 0;
    localparam int FL_HI_BIT = 1;

    // reset values
    localparam logic [7:0] MODE_RESET = 8'h00;
    localparam logic [7:0] DATA_RESET = 8'h00;
    localparam logic [1:0] FLAG_RESET = 2'h0;
    localparam logic [PRE_W-1:0] PRE_RESET = 11'h000;
    localparam logic [31:0] RDATA_RESET = 32'h0000_0000;

    // selector codes
    localparam logic [2:0] SEL_A_EVENT = 3'h7;
    localparam logic [1:0] SEL_B_CHAIN = 2'h3;
    localparam logic [1:0] EDGE_FALL = 2'h0;
    localparam logic [1:0] EDGE_RISE = 2'h1;
    localparam logic [1:0] EDGE_BOTH = 2'h2;

    // ahb codes
    localparam logic [1:0] HRESP_OKAY = 2'h0;

    typedef enum logic [2:0] {
        REG_NONE, REG_MODE_A, REG_MODE_B, REG_COUNT_LO, REG_COUNT_HI,
        REG_FLAG
    } ptc_reg_type;

    typedef enum logic {ST_IDLE, ST_READ_WAIT} ptc_bus_state_type;

    // offset to register inside a pair block
    function automatic ptc_reg_type ptc_decode(input logic [4:0] ofs);
        if (ofs == OFS_MODE_A) begin
            return REG_MODE_A;
        end else if (ofs == OFS_MODE_B) begin
            return REG_MODE_B;
        end else if (ofs == OFS_COUNT_LO) begin
            return REG_COUNT_LO;
        end else if (ofs == OFS_COUNT_HI) begin
            return REG_COUNT_HI;
        end else if (ofs == OFS_FLAG) begin
            return REG_FLAG;
        end else begin
            return REG_NONE;
        end
    endfunction

    // first timer: divide by 2,4,8,32,128,512,2048 as power of two
    function automatic logic [SHIFT_W-1:0] ptc_shift_a(
            input logic [2:0] sel);
        case (sel)
            3'h0: return 4'h1;
            3'h1: return 4'h2;
            3'h2: return 4'h3;
            3'h3: return 4'h5;
            3'h4: return 4'h7;
            3'h5: return 4'h9;
            default: return 4'hB;
        endcase
    endfunction

    // second timer: divide by 1,2,8
    function automatic logic [SHIFT_W-1:0] ptc_shift_b(
            input logic [1:0] sel);
        case (sel)
            2'h0: return 4'h0;
            2'h1: return 4'h1;
            default: return 4'h3;
        endcase
    endfunction

    // one-cycle tick when the low sh bits of the prescaler are all ones
    function automatic logic ptc_tick(input logic [PRE_W-1:0] pre,
            input logic [SHIFT_W-1:0] sh);
        logic [PRE_W-1:0] mask;
        mask = ~({PRE_W{1'b1}} << sh);
        return (pre & mask) == mask;
    endfunction

    // capture edge detect on a synchronised level
    function automatic logic ptc_edge_hit(input logic [1:0] sel,
            input logic now, input logic prev);
        case (sel)
            EDGE_FALL: return prev & ~now;
            EDGE_RISE: return now & ~prev;
            EDGE_BOTH: return now ^ prev;
            default: return 1'b0;
        endcase
    endfunction

endpackage

`default_nettype wire

// >>> core/ptc_timer_pair.sv
// Purpose: one pair of 8-bit timers, cascadable to 16 bits
// Assumes: prescaler value shared from the top, pins are asynchronous
// Notes:   all outputs registered; match outputs pulse once per tick, so match_hi stays high at divide by 1 with match value 0
`default_nettype none

module ptc_timer_pair (
    input wire logic hclk, // system clock
    input wire logic hresetn, // async reset
    input wire logic [ptc_pkg::PRE_W-1:0] prescale, // shared divider
    input wire logic [7:0] mode_a, // first mode reg
    input wire logic [7:0] mode_b, // second mode reg
    input wire logic [7:0] data_lo, // first match value
    input wire logic [7:0] data_hi, // second match value
    input wire logic event_pin, // raw event input
    input wire logic [1:0] trigger_pin, // raw capture pins
    output logic [7:0] count_lo, // first count
    output logic [7:0] count_hi, // second count
    output logic [7:0] capture_lo, // first capture
    output logic [7:0] capture_hi, // second capture
    output logic match_lo, // first match pulse
    output logic match_hi, // second match pulse
    output logic compare_out // compare pin level
);
    import ptc_pkg::*;

    logic ev_s1, ev_s2, ev_prev;
    logic [1:0] trg_s1, trg_s2, trg_prev;
    logic [2:0] sel_a;
    logic [1:0] sel_b, edge_sel;
    logic cap_a_en, cap_b_en, pw_en, casc, cmp_sel;
    logic ev_rise, tick_a, tick_b, cmp_hit;
    logic [1:0] trg_hit;
    logic [15:0] cnt16, dat16;
    logic [7:0] next_count_lo, next_count_hi;
    logic [7:0] next_capture_lo, next_capture_hi;
    logic next_match_lo, next_match_hi, next_compare_out;

    // pin synchronisers; the second stage and its delayed copy feed the edge logic
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ev_s1 <= 1'b0;
            ev_s2 <= 1'b0;
            ev_prev <= 1'b0;
            trg_s1 <= 2'h0;
            trg_s2 <= 2'h0;
            trg_prev <= 2'h0;
        end else begin
            ev_s1 <= event_pin;
            ev_s2 <= ev_s1;
            ev_prev <= ev_s2;
            trg_s1 <= trigger_pin;
            trg_s2 <= trg_s1;
            trg_prev <= trg_s2;
        end
    end

    // mode fields and count sources
    always_comb begin
        sel_a = mode_a[FA_CLK_LSB +: 3];
        cap_a_en = mode_a[FA_CAP_BIT];
        edge_sel = mode_a[FA_EDGE_LSB +: 2];
        sel_b = mode_b[FB_CLK_LSB +: 2];
        cap_b_en = mode_b[FB_CAP_BIT];
        pw_en = mode_b[FB_PWE_BIT];
        casc = mode_b[FB_CASC_BIT];
        cmp_sel = mode_b[FB_CMP_BIT];
        ev_rise = ev_s2 & ~ev_prev; // R05
        trg_hit[0] = ptc_edge_hit(edge_sel, trg_s2[0], trg_prev[0]);
        trg_hit[1] = ptc_edge_hit(edge_sel, trg_s2[1], trg_prev[1]);
        // event pin or prescaler tap for the first timer
        tick_a = (sel_a == SEL_A_EVENT) ? ev_rise : // R14
            ptc_tick(prescale, ptc_shift_a(sel_a)); // R03
        // second timer never sees the event pin; chain code stops it alone
        tick_b = (sel_b == SEL_B_CHAIN) ? 1'b0 : // R06
            ptc_tick(prescale, ptc_shift_b(sel_b)); // R04
        cnt16 = {count_hi, count_lo};
        dat16 = {data_hi, data_lo};
    end

    // count, capture and compare next values
    always_comb begin
        next_count_lo = count_lo;
        next_count_hi = count_hi;
        next_capture_lo = capture_lo;
        next_capture_hi = capture_hi;
        next_match_lo = 1'b0;
        next_match_hi = 1'b0;
        next_compare_out = compare_out;
        if (casc) begin // R02 R15
            // capture clears the count, and wins over a tick that cycle
            if (cap_a_en && trg_hit[0]) begin
                {next_capture_hi, next_capture_lo} = cnt16; // R16
                {next_count_hi, next_count_lo} = 16'h0000; // R19
            end else if (tick_a) begin
                if (cnt16 == dat16) begin
                    {next_count_hi, next_count_lo} = 16'h0000; // R12
                    next_match_lo = 1'b1; // R12
                end else begin
                    {next_count_hi, next_count_lo} = cnt16 + 16'h0001;
                end
            end
        end else begin
            if (cap_a_en && trg_hit[0]) begin
                next_capture_lo = count_lo; // R16
                next_count_lo = 8'h00; // R19
            end else if (tick_a) begin
                if (count_lo == data_lo) begin
                    next_count_lo = 8'h00; // R08
                    next_match_lo = 1'b1; // R09
                end else begin
                    next_count_lo = count_lo + 8'h01;
                end
            end
            if (cap_b_en && trg_hit[1]) begin
                next_capture_hi = count_hi; // R16
                next_count_hi = 8'h00; // R19
            end else if (tick_b) begin
                if (count_hi == data_hi) begin
                    next_count_hi = 8'h00; // R08
                    next_match_hi = 1'b1; // R09
                end else begin
                    next_count_hi = count_hi + 8'h01;
                end
            end
        end
        // second timer, or the 16-bit match in cascade, drives the compare pin; the pwm engine is not
        // built here, so the pin rests low while pulse width is chosen
        cmp_hit = casc ? next_match_lo : next_match_hi; // R17
        if (pw_en) begin
            next_compare_out = 1'b0;
        end else if (cmp_sel && cmp_hit) begin
            next_compare_out = ~compare_out; // R18 R21 R22
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            count_lo <= DATA_RESET;
            count_hi <= DATA_RESET;
            capture_lo <= DATA_RESET;
            capture_hi <= DATA_RESET;
            match_lo <= 1'b0;
            match_hi <= 1'b0;
            compare_out <= 1'b0;
        end else begin
            count_lo <= next_count_lo;
            count_hi <= next_count_hi;
            capture_lo <= next_capture_lo;
            capture_hi <= next_capture_hi;
            match_lo <= next_match_lo;
            match_hi <= next_match_hi;
            compare_out <= next_compare_out;
        end
    end

endmodule

`default_nettype wire

// >>> core/ptc_paired_timer_counter_unit.sv
// Purpose: two timer pairs with an AHB-Lite register slave
// Assumes: single word transfers, one 200 MHz clock, async pins
// Notes:   writes take no wait state, reads take one
//
// Overview of operation
// (R01) four timers as two identical pairs
// (R02) pair runs as two 8-bit or one 16-bit
// (R03) first timer prescale 2 to 2048
// (R04) second timer prescale 1, 2 or 8
// (R05) counter counts rising edges of event pin
// (R06) only first timer counts external events
// (R07) software sets event pin as input
// (R08) 8-bit count runs to match then zero
// (R09) match raises request and sets flag
// (R10) count read, match value written, one address
// (R11) software clears capture and cascade for 8-bit
// (R12) 16-bit match clears, raises first request only
// (R13) software sets chain code and cascade for 16-bit
// (R14) 16-bit clock from first clock select
// (R15) mode bits decode the seven operating modes
// (R16) capture copies count on selected trigger edge
// (R17) second timer feeds compare and pulse width; pulse width is not built, the pin is held low
// (R18) compare pin gives equal-halves square wave
// (R19) capture clears count and restarts it
// (R20) capture mode reads capture value, not count
// (R21) compare frequency follows prescale and match value
// (R22) compare pin toggles on every match
// (R23) reset clears all mode and clock bits
//
// Local design decisions: the AHB-Lite interface to the registers and the register addresses.
`default_nettype none

module ptc_paired_timer_counter_unit (
    input wire logic hclk, // system clock
    input wire logic hresetn, // async reset, low
    input wire logic hsel, // slave select
    input wire logic [31:0] haddr, // byte address
    input wire logic [1:0] htrans, // transfer type
    input wire logic hwrite, // write when high
    input wire logic [2:0] hsize, // word only
    input wire logic [31:0] hwdata, // write data
    input wire logic hready, // bus ready in
    output logic hreadyout, // slave ready
    output logic hresp, // always okay
    output logic [31:0] hrdata, // read data
    input wire logic [1:0] event_input_pin, // event pin per pair
    input wire logic [3:0] capture_trigger_pin, // trigger per timer
    output logic [3:0] match_request, // match pulse per timer
    output logic [1:0] compare_output_pin, // compare level per pair
    output logic [1:0] compare_output_enable // pin driven when high
);
    import ptc_pkg::*;

    ptc_bus_state_type state, next_state;
    logic [PRE_W-1:0] prescale, next_prescale;
    logic [7:0] first_mode_register [PAIRS];
    logic [7:0] second_mode_register [PAIRS];
    logic [7:0] first_match_value [PAIRS];
    logic [7:0] second_match_value [PAIRS];
    logic [1:0] flag [PAIRS];
    logic [7:0] next_mode_a [PAIRS];
    logic [7:0] next_mode_b [PAIRS];
    logic [7:0] next_data_lo [PAIRS];
    logic [7:0] next_data_hi [PAIRS];
    logic [1:0] next_flag [PAIRS];
    logic [7:0] count_lo [PAIRS];
    logic [7:0] count_hi [PAIRS];
    logic [7:0] capt_lo [PAIRS];
    logic [7:0] capt_hi [PAIRS];
    logic [PAIRS-1:0] match_lo, match_hi;
    logic wr_pend, next_wr_pend;
    ptc_reg_type wr_reg, next_wr_reg, rd_reg, next_rd_reg, addr_reg;
    logic wr_pair, next_wr_pair, rd_pair, next_rd_pair;
    logic [31:0] next_hrdata;
    logic accept;

    // free-running prescaler shared by all timers
    always_comb begin
        next_prescale = prescale + 11'h001;
    end

    // both pairs are the same module
    for (genvar p = 0; p < PAIRS; p++) begin : g_pair
        ptc_timer_pair u_pair ( // R01
            .hclk(hclk),
            .hresetn(hresetn),
            .prescale(prescale),
            .mode_a(first_mode_register[p]),
            .mode_b(second_mode_register[p]),
            .data_lo(first_match_value[p]),
            .data_hi(second_match_value[p]),
            .event_pin(event_input_pin[p]),
            .trigger_pin(capture_trigger_pin[2*p +: 2]),
            .count_lo(count_lo[p]),
            .count_hi(count_hi[p]),
            .capture_lo(capt_lo[p]),
            .capture_hi(capt_hi[p]),
            .match_lo(match_lo[p]),
            .match_hi(match_hi[p]),
            .compare_out(compare_output_pin[p])
        );
        assign match_request[2*p] = match_lo[p]; // R09
        assign match_request[2*p+1] = match_hi[p]; // R09
        assign compare_output_enable[p] =
            second_mode_register[p][FB_CMP_BIT] &
            ~second_mode_register[p][FB_PWE_BIT];
    end

    // the slave never errors and stalls only during a read
    assign hresp = HRESP_OKAY[0];
    assign hreadyout = (state != ST_READ_WAIT);
    assign accept = hsel & hready & htrans[1];

    // address phase decode; anything above the map reads as zero
    always_comb begin
        if (haddr[31:MAP_TOP_BIT] == 26'h0) begin
            addr_reg = ptc_decode(haddr[4:0]);
        end else begin
            addr_reg = REG_NONE;
        end
    end

    // bus sequencing: a read waits one cycle so a write just before it
    // lands first, which keeps back-to-back write-read coherent
    always_comb begin
        next_state = state;
        next_wr_pend = 1'b0;
        next_wr_reg = wr_reg;
        next_wr_pair = wr_pair;
        next_rd_reg = rd_reg;
        next_rd_pair = rd_pair;
        case (state)
            ST_IDLE: begin
                if (accept && hwrite) begin
                    next_wr_pend = 1'b1;
                    next_wr_reg = addr_reg;
                    next_wr_pair = haddr[PAIR_SEL_BIT];
                end else if (accept) begin
                    next_state = ST_READ_WAIT;
                    next_rd_reg = addr_reg;
                    next_rd_pair = haddr[PAIR_SEL_BIT];
                end
            end
            ST_READ_WAIT: begin
                next_state = ST_IDLE;
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    // read mux; capture mode shows the captured value at the count slot
    always_comb begin
        next_hrdata = hrdata;
        if (state == ST_READ_WAIT) begin
            next_hrdata = 32'h0000_0000;
            if (rd_reg == REG_MODE_A) begin
                next_hrdata[7:0] = first_mode_register[rd_pair];
            end else if (rd_reg == REG_MODE_B) begin
                next_hrdata[7:0] = second_mode_register[rd_pair];
            end else if (rd_reg == REG_COUNT_LO) begin
                if (first_mode_register[rd_pair][FA_CAP_BIT]) begin
                    next_hrdata[7:0] = capt_lo[rd_pair]; // R20
                end else begin
                    next_hrdata[7:0] = count_lo[rd_pair]; // R10
                end
            end else if (rd_reg == REG_COUNT_HI) begin
                if (second_mode_register[rd_pair][FB_CAP_BIT] ||
                        (second_mode_register[rd_pair][FB_CASC_BIT] &&
                        first_mode_register[rd_pair][FA_CAP_BIT])) begin
                    next_hrdata[7:0] = capt_hi[rd_pair]; // R20
                end else begin
                    next_hrdata[7:0] = count_hi[rd_pair]; // R10
                end
            end else if (rd_reg == REG_FLAG) begin
                next_hrdata[1:0] = flag[rd_pair];
            end
        end
    end

    // register writes in the data phase; flags clear by writing ones,
    // and a match in the same cycle keeps its flag set
    always_comb begin
        for (int p = 0; p < PAIRS; p++) begin
            next_mode_a[p] = first_mode_register[p];
            next_mode_b[p] = second_mode_register[p];
            next_data_lo[p] = first_match_value[p];
            next_data_hi[p] = second_match_value[p];
            next_flag[p] = flag[p];
            if (wr_pend && (wr_pair == p[0])) begin
                if (wr_reg == REG_MODE_A) begin
                    next_mode_a[p] = hwdata[7:0]; // R15
                end else if (wr_reg == REG_MODE_B) begin
                    next_mode_b[p] = hwdata[7:0]; // R15
                end else if (wr_reg == REG_COUNT_LO) begin
                    next_data_lo[p] = hwdata[7:0]; // R10
                end else if (wr_reg == REG_COUNT_HI) begin
                    next_data_hi[p] = hwdata[7:0]; // R10
                end else if (wr_reg == REG_FLAG) begin
                    next_flag[p] = flag[p] & ~hwdata[1:0];
                end
            end
            next_flag[p][FL_LO_BIT] = next_flag[p][FL_LO_BIT] |
                match_lo[p]; // R09
            next_flag[p][FL_HI_BIT] = next_flag[p][FL_HI_BIT] |
                match_hi[p]; // R09
        end
    end

    // bus, prescaler and register state registered here, counts in the pairs; reset leaves timers in 8-bit mode
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state <= ST_IDLE;
            prescale <= PRE_RESET;
            wr_pend <= 1'b0;
            wr_reg <= REG_NONE;
            rd_reg <= REG_NONE;
            wr_pair <= 1'b0;
            rd_pair <= 1'b0;
            hrdata <= RDATA_RESET;
            for (int p = 0; p < PAIRS; p++) begin
                first_mode_register[p] <= MODE_RESET; // R23
                second_mode_register[p] <= MODE_RESET; // R23
                first_match_value[p] <= DATA_RESET;
                second_match_value[p] <= DATA_RESET;
                flag[p] <= FLAG_RESET;
            end
        end else begin
            state <= next_state;
            prescale <= next_prescale;
            wr_pend <= next_wr_pend;
            wr_reg <= next_wr_reg;
            rd_reg <= next_rd_reg;
            wr_pair <= next_wr_pair;
            rd_pair <= next_rd_pair;
            hrdata <= next_hrdata;
            for (int p = 0; p < PAIRS; p++) begin
                first_mode_register[p] <= next_mode_a[p];
                second_mode_register[p] <= next_mode_b[p];
                first_match_value[p] <= next_data_lo[p];
                second_match_value[p] <= next_data_hi[p];
                flag[p] <= next_flag[p];
            end
        end
    end

endmodule

`default_nettype wire

// >>> verif/ptc_properties.sv
// Purpose: checks on bus answers and timer outputs
// Assumes: one clock, async active-low reset
// Notes:   bound to the unit top, sees its ports only
`default_nettype none
module ptc_properties (
    input wire logic hclk, // clock
    input wire logic hresetn, // reset
    input wire logic hsel, // select
    input wire logic [1:0] htrans, // type
    input wire logic hwrite, // direction
    input wire logic hready, // ready in
    input wire logic hreadyout, // ready out
    input wire logic hresp, // response
    input wire logic [31:0] hrdata, // read data
    input wire logic [3:0] match_request, // match pulses
    input wire logic [1:0] compare_output_pin, // compare pins
    input wire logic [1:0] compare_output_enable // pin enables
);
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // a transfer counts only when the bus is ready
    wire logic take = hsel && hready && htrans[1];
    sequence s_wait; !hreadyout ##1 hreadyout; endsequence
    property p_rd; take && !hwrite |=> s_wait; endproperty
    a_rd: assert property (p_rd) else $error("read wait wrong");
    property p_wr; take && hwrite |=> hreadyout; endproperty
    a_wr: assert property (p_wr) else $error("write stalled");
    property p_cause; !hreadyout |-> $past(take && !hwrite); endproperty
    a_cause: assert property (p_cause) else $error("stray wait");
    // read data may only move when a read completes
    property p_hold;
        $changed(hrdata) |-> hreadyout && $past(!hreadyout);
    endproperty
    a_hold: assert property (p_hold) else $error("hrdata moved");
    property p_resp; hresp == 1'h0; endproperty
    a_resp: assert property (p_resp) else $error("not okay");
    property p_upper; hrdata[31:8] == 24'h0; endproperty
    a_upper: assert property (p_upper) else $error("upper bits");
    property p_pulse0; match_request[0] |=> !match_request[0]; endproperty
    a_pulse0: assert property (p_pulse0) else $error("wide pulse");
    property p_pulse2; match_request[2] |=> !match_request[2]; endproperty
    a_pulse2: assert property (p_pulse2) else $error("wide pulse");
    // a rise of the enabled pair 0 compare pin needs a recent pair 0 match
    property p_cmp;
        $rose(compare_output_pin[0]) && $past(compare_output_enable[0])
        |-> (|match_request[1:0]) || $past(|match_request[1:0])
        || $past(|match_request[1:0], 2);
    endproperty
    a_cmp: assert property (p_cmp) else $error("toggle no match");
endmodule
bind ptc_paired_timer_counter_unit ptc_properties ptc_properties_inst (
    .hclk, .hresetn, .hsel, .htrans, .hwrite, .hready, .hreadyout, .hresp,
    .hrdata, .match_request, .compare_output_pin, .compare_output_enable);
`default_nettype wire

// >>> verif/ptc_paired_timer_counter_unit_tb.sv
// Purpose: self-checking bench of the paired timer unit
// Assumes: reads answer after one wait state
// Notes:   a monitor checks read data against a queue of notes
`default_nettype none
`define CHK(n, e, s) begin checks_done++; if ((s) !== (e)) begin \
    err_count++; $display("BAD %s exp %0h got %0h", n, e, s); end end
module ptc_paired_timer_counter_unit_tb;
    timeunit 1ns;
    timeprecision 100ps;
    import ptc_pkg::*;
    logic hclk = 1'h0, hresetn = 1'h0, hsel = 1'h0, hwrite = 1'h0;
    logic [31:0] haddr = '0, hwdata = '0, seed = 32'h9B2ACAFA, x;
    logic [1:0] htrans = 2'h0;
    logic [5:0] pins = 6'h00;
    logic hreadyout, hresp;
    logic [31:0] hrdata;
    logic [3:0] mreq;
    logic [1:0] cpin, cen;
    wire logic [5:0] vec = {cpin, mreq};
    int err_count = 0, checks_done = 0, b, n;
    int dv[7] = '{2, 4, 8, 32, 128, 512, 2048};
    int db[3] = '{1, 2, 8};
    logic [31:0] q[$];
    logic pend = 1'h0;
    ptc_paired_timer_counter_unit ptc_paired_timer_counter_unit_inst (
        .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2),
        .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata,
        .event_input_pin(pins[1:0]),
        .capture_trigger_pin(pins[5:2]), .match_request(mreq),
        .compare_output_pin(cpin), .compare_output_enable(cen));
    // free-running 200 MHz clock
    initial forever #2.5 hclk = ~hclk;
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // one single transfer; upper write bits are random and ignored
    task automatic bus(input logic w, input logic [31:0] a,
            input logic [7:0] d);
        seed = lfsr(seed);
        if (!w) q.push_back({24'h0, d});
        hsel <= 1'h1;
        hwrite <= w;
        haddr <= b + a;
        htrans <= 2'h2;
        @(posedge hclk);
        while (!hreadyout) @(posedge hclk);
        htrans <= 2'h0;
        hwdata <= {seed[23:0], d};
        @(posedge hclk);
        while (!hreadyout) @(posedge hclk);
    endtask
    // cycles between the second and third rise of vec[i]
    task automatic gap(input int i, input int e, input bit o);
        int r = 0, k = 0, c = 0;
        logic pv = 1'h1;
        while (r < 3) begin
            @(posedge hclk);
            if (r == 2) c++;
            if (r == 2 && vec[i ^ 1]) k++;
            if (vec[i] && !pv) r++;
            pv = vec[i];
        end
        `CHK("gap", e, c)
        if (o) `CHK("partner pulses", 0, k)
    endtask
    // slow pulses so the pin synchroniser sees every edge
    task automatic tog(input int k, input int m);
        repeat (m) begin
            pins[k] <= 1'h1;
            repeat (4) @(posedge hclk);
            pins[k] <= 1'h0;
            repeat (4) @(posedge hclk);
        end
    endtask
    task automatic results;
        $display("checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // monitor: a completed read takes the oldest note
    always @(posedge hclk) begin
        if (pend && hreadyout) begin
            x = q.pop_front();
            `CHK("hrdata", x, hrdata)
            pend = 1'h0;
        end
        if (hsel && hreadyout && htrans[1] && !hwrite) pend = 1'h1;
    end
    // watchdog sized well above the longest prescale sweep
    initial begin
        repeat (60000) @(posedge hclk);
        err_count++;
        results();
    end
    initial begin
        repeat (4) @(posedge hclk);
        hresetn <= 1'h1;
        @(posedge hclk);
        bus('1, 32'h40, 8'h5A);
        bus('0, 32'h40, 8'h00);
        for (int p = 0; p < 2; p++) begin
            b = p * 32;
            bus('0, OFS_MODE_A, 8'h00);
            bus('0, OFS_MODE_B, 8'h00);
            // timers run from reset, so both match flags are already set
            bus('0, OFS_FLAG, 8'h03);
            bus('1, OFS_COUNT_LO, 8'h01);
            for (int s = 0; s < 7; s++) begin
                bus('1, OFS_MODE_A, 8'(s));
                gap(2 * p, 2 * dv[s], 1'b0);
            end
            bus('1, OFS_COUNT_HI, 8'h01);
            for (int s = 0; s < 3; s++) begin
                bus('1, OFS_MODE_B, 8'(s));
                gap(2 * p + 1, 2 * db[s], 1'b0);
            end
            bus('1, OFS_MODE_A, 8'h00);
            bus('1, OFS_MODE_B, 8'h13);
            gap(2 * p, 516, 1'b1);
            bus('1, OFS_COUNT_HI, 8'h03);
            bus('1, OFS_MODE_B, 8'h20);
            gap(4 + p, 8, 1'b0);
            `CHK("enable", 1'h1, cen[p])
            bus('1, OFS_MODE_B, 8'h28);
            repeat (3) @(posedge hclk);
            `CHK("pin off", 2'h0, {cen[p], cpin[p]})
            bus('1, OFS_MODE_B, 8'h03);
            bus('1, OFS_COUNT_LO, 8'hFF);
            bus('1, OFS_MODE_A, 8'h1F);
            tog(2 + 2 * p, 1);
            n = int'(seed[2:0]) + 1;
            tog(p, n);
            tog(2 + 2 * p, 1);
            bus('0, OFS_COUNT_LO, 8'(n));
            bus('1, OFS_MODE_A, 8'h17);
            bus('0, OFS_COUNT_LO, 8'h00);
            bus('0, OFS_FLAG, 8'h03);
            bus('1, OFS_FLAG, 8'h03);
            bus('0, OFS_FLAG, 8'h00);
            $display("test pair %0d done", p);
        end
        repeat (4) @(posedge hclk);
        results();
    end
endmodule
`default_nettype wire
